//--- core/instr_exec_defines.svh
// constants for the move and return execution unit: widths, opcode patterns, timing.
// assumes a 14-bit instruction word, a 13-bit instruction pointer and 8-bit data.
// How it works
// - accumulator copied to 7-bit file address, one cycle
// - 8-bit literal loaded into accumulator, one cycle
// - interrupt return pops stack into instr_pointer
// - interrupt return sets global_irq_enable, control bit 7
// - all three returns take two cycles
// - return_with_literal loads literal and stack top
// - plain return pops stack, keeps accumulator, enable
`ifndef INSTR_EXEC_DEFINES_SVH
`define INSTR_EXEC_DEFINES_SVH

// word and field widths
`define INSTR_W        14
`define PTR_W          13
`define DATA_W         8
`define FADDR_W        7

// position of the global enable in the interrupt control register
`define IRQ_EN_BIT     7

// opcode match masks and values (14-bit words)
`define MASK_ACC_TO_FILE  14'h3f80
`define VAL_ACC_TO_FILE   14'h0080
`define MASK_LIT_LOAD     14'h3c00
`define VAL_LIT_LOAD      14'h3000
`define MASK_IDLE         14'h3f9f
`define VAL_IDLE          14'h0000
`define MASK_EXACT        14'h3fff
`define VAL_IRQ_RETURN    14'h0009
`define VAL_SUB_RETURN    14'h0008
`define MASK_RET_LIT      14'h3c00
`define VAL_RET_LIT       14'h3400

// execution lengths in instruction cycles
`define CYC_SINGLE     1
`define CYC_RETURN     2

// reset values
`define RST_ACC        8'h00
`define RST_PTR        13'h0000

`endif

//--- core/instr_exec_pkg.sv
// types shared by the decoder and the execution unit.
// assumes instr_exec_defines.svh is on the include path.
package instr_exec_pkg;
  // decoded instruction kind
  typedef enum logic [2:0] {
    OP_OTHER          = 3'h0,
    OP_ACC_TO_FILE    = 3'h1,
    OP_LIT_LOAD       = 3'h2,
    OP_IDLE           = 3'h3,
    OP_IRQ_RETURN     = 3'h4,
    OP_RET_LIT        = 3'h5,
    OP_SUB_RETURN     = 3'h6
  } op_e;
  // execution sequencer, one-hot
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_e;
endpackage

//--- core/instr_op_decode.sv
// combinational decoder from a 14-bit instruction word to an op kind.
// assumes the word is stable while it is presented.
`timescale 1ns/1ps
`default_nettype none
`include "instr_exec_defines.svh"
module instr_op_decode (
  // instruction word in
  input  wire logic [`INSTR_W-1:0]   instr_word,
  // decoded kind out
  output var  instr_exec_pkg::op_e   op
);
  import instr_exec_pkg::*;

  // exact codes first, then the masked families
  always_comb begin
    if ((instr_word & `MASK_EXACT) == `VAL_IRQ_RETURN) begin
      op = OP_IRQ_RETURN;
    end else if ((instr_word & `MASK_EXACT) == `VAL_SUB_RETURN) begin
      op = OP_SUB_RETURN;
    end else if ((instr_word & `MASK_ACC_TO_FILE) == `VAL_ACC_TO_FILE) begin
      op = OP_ACC_TO_FILE;
    end else if ((instr_word & `MASK_LIT_LOAD) == `VAL_LIT_LOAD) begin
      // don't-care bits ignored, software fills them with zeros
      op = OP_LIT_LOAD;
    end else if ((instr_word & `MASK_RET_LIT) == `VAL_RET_LIT) begin
      op = OP_RET_LIT;
    end else if ((instr_word & `MASK_IDLE) == `VAL_IDLE) begin
      op = OP_IDLE;
    end else begin
      op = OP_OTHER;
    end
  end
endmodule // instr_op_decode
`default_nettype wire

//--- core/move_and_return_instr_exec.sv
// execution unit for accumulator/literal moves, the idle instruction and the three returns.
// assumes the fetch path holds a word until taken and the stack presents its top at all times.
`timescale 1ns/1ps
`default_nettype none
`include "instr_exec_defines.svh"
module move_and_return_instr_exec (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // instruction fetch side
  input  wire logic                  instr_valid,
  input  wire logic [`INSTR_W-1:0]   instr_word,
  output logic                       instr_ready,
  output logic [`PTR_W-1:0]          instr_pointer,
  // return stack side
  input  wire logic [`PTR_W-1:0]     return_stack_top,
  output logic                       stack_pop,
  // register file side
  output logic                       file_we,
  output logic [`FADDR_W-1:0]        file_addr,
  output logic [`DATA_W-1:0]         file_wdata,
  // accumulator and interrupt enable
  output logic [`DATA_W-1:0]         acc,
  output logic                       global_irq_enable,
  input  wire logic                  irq_enable_clear
);
  import instr_exec_pkg::*;

  op_e                 op;            // decoded kind of the offered word
  logic                take;          // word accepted this edge
  exec_state_e         state_q;       // sequencer state
  exec_state_e         state_d;
  logic [`PTR_W-1:0]   ptr_q;         // instruction pointer
  logic [`PTR_W-1:0]   ptr_d;
  logic [`DATA_W-1:0]  acc_q;         // working accumulator
  logic [`DATA_W-1:0]  acc_d;
  logic                irq_en_q;      // global interrupt enable, control bit 7
  logic                irq_en_d;
  logic                pop_q;         // one-cycle stack pop strobe
  logic                pop_d;
  logic                fwe_q;         // one-cycle file write strobe
  logic                fwe_d;
  logic [`FADDR_W-1:0] faddr_q;       // file write address
  logic [`FADDR_W-1:0] faddr_d;
  logic [`DATA_W-1:0]  fdata_q;       // file write data
  logic [`DATA_W-1:0]  fdata_d;

  // decoder for the offered word
  instr_op_decode u_decode (
    .instr_word (instr_word),
    .op         (op)
  );

  // no word is taken in the second cycle of a return
  assign instr_ready = (state_q == ST_EXEC);
  assign take        = instr_valid && instr_ready;

  // next-state and datapath computation
  always_comb begin
    state_d = state_q;
    ptr_d   = ptr_q;
    acc_d   = acc_q;
    irq_en_d = irq_en_q;
    pop_d   = 1'b0;
    fwe_d   = 1'b0;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    // interrupt entry clears the enable; an interrupt return in the same cycle wins
    if (irq_enable_clear) begin
      irq_en_d = 1'b0;
    end
    case (state_q)
      ST_EXEC: begin
        if (take) begin
          case (op)
            OP_ACC_TO_FILE: begin
              // copy accumulator to the addressed file register
              fwe_d   = 1'b1;
              faddr_d = instr_word[`FADDR_W-1:0];
              fdata_d = acc_q;
              ptr_d   = ptr_q + `PTR_W'(1);
            end
            OP_LIT_LOAD: begin
              // literal into accumulator, single cycle
              acc_d = instr_word[`DATA_W-1:0];
              ptr_d = ptr_q + `PTR_W'(1);
            end
            OP_IDLE: begin
              // nothing but the pointer moves
              ptr_d = ptr_q + `PTR_W'(1);
            end
            OP_IRQ_RETURN: begin
              // pop, reload pointer, re-enable interrupts
              pop_d   = 1'b1;
              ptr_d   = return_stack_top;
              irq_en_d = 1'b1;
              state_d = ST_FLUSH;
            end
            OP_RET_LIT: begin
              // literal into accumulator and return
              acc_d   = instr_word[`DATA_W-1:0];
              pop_d   = 1'b1;
              ptr_d   = return_stack_top;
              state_d = ST_FLUSH;
            end
            OP_SUB_RETURN: begin
              // return, accumulator and enable untouched
              pop_d   = 1'b1;
              ptr_d   = return_stack_top;
              state_d = ST_FLUSH;
            end
            default: begin
              // words of other units: only step past them
              ptr_d = ptr_q + `PTR_W'(1);
            end
          endcase
        end
      end
      ST_FLUSH: begin
        // dead second cycle of a return
        state_d = ST_EXEC;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  // registers only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_EXEC;
      ptr_q   <= `RST_PTR;
      acc_q   <= `RST_ACC;
      irq_en_q <= 1'b0;
      pop_q   <= 1'b0;
      fwe_q   <= 1'b0;
      faddr_q <= '0;
      fdata_q <= '0;
    end else begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      acc_q   <= acc_d;
      irq_en_q <= irq_en_d;
      pop_q   <= pop_d;
      fwe_q   <= fwe_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
    end
  end

  // outputs straight from flops
  assign instr_pointer     = ptr_q;
  assign acc               = acc_q;
  assign global_irq_enable = irq_en_q;
  assign stack_pop         = pop_q;
  assign file_we           = fwe_q;
  assign file_addr         = faddr_q;
  assign file_wdata        = fdata_q;

  // file write carries the accumulator and operand of the taken word
  chk_file_write_data: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_ACC_TO_FILE |=> file_we && file_wdata == $past(acc_q)
      && file_addr == $past(instr_word[`FADDR_W-1:0]) && instr_ready)
    else $error("file write wrong after accumulator move");

  // literal load lands in the accumulator in one cycle
  chk_literal_load: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_LIT_LOAD |=> acc == $past(instr_word[`DATA_W-1:0])
      && !file_we && !stack_pop && instr_ready)
    else $error("literal load did not reach accumulator");

  // interrupt return reloads pointer from the stack top
  chk_irq_ret_ptr: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_IRQ_RETURN |=> stack_pop && instr_pointer == $past(return_stack_top))
    else $error("interrupt return pointer or pop wrong");

  // interrupt return leaves interrupts enabled
  chk_irq_ret_enable: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_IRQ_RETURN |=> global_irq_enable)
    else $error("interrupt return did not set enable");

  // every return stalls fetch for exactly one further cycle
  chk_return_two_cyc: assert property (@(posedge clk) disable iff (!resetn)
    take && (op == OP_IRQ_RETURN || op == OP_RET_LIT || op == OP_SUB_RETURN)
      |=> !instr_ready ##1 instr_ready && !stack_pop)
    else $error("return did not take two cycles");

  // return with literal sets accumulator and pointer together
  chk_ret_lit_both: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_RET_LIT |=> acc == $past(instr_word[`DATA_W-1:0])
      && instr_pointer == $past(return_stack_top) && stack_pop)
    else $error("return with literal result wrong");

  // plain return keeps accumulator and enable
  chk_sub_ret_keep: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_SUB_RETURN && !irq_enable_clear |=> $stable(acc) && $stable(global_irq_enable)
      && instr_pointer == $past(return_stack_top))
    else $error("plain return disturbed state");

  // idle word moves only the pointer, by one
  chk_idle_step: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_IDLE && !irq_enable_clear |=> instr_pointer == $past(instr_pointer) + `PTR_W'(1)
      && $stable(acc) && $stable(global_irq_enable) && !file_we && !stack_pop)
    else $error("idle instruction changed state");

  // a pop strobe never stands for two cycles
  chk_pop_single: assert property (@(posedge clk) disable iff (!resetn)
    stack_pop |=> !stack_pop)
    else $error("stack pop lasted more than one cycle");

  // interrupt entry clears the enable unless an interrupt return is taken
  chk_enable_clear: assert property (@(posedge clk) disable iff (!resetn)
    irq_enable_clear && !(take && op == OP_IRQ_RETURN) |=> !global_irq_enable)
    else $error("enable clear did not take effect");

  // words of other units only step the pointer
  chk_other_step: assert property (@(posedge clk) disable iff (!resetn)
    take && op == OP_OTHER |=> instr_pointer == $past(instr_pointer) + `PTR_W'(1)
      && $stable(acc) && !file_we && !stack_pop)
    else $error("unknown word changed state");

endmodule // move_and_return_instr_exec
`default_nettype wire

//--- verif/tb_move_and_return_instr_exec.sv
// directed testbench for the move and return execution unit.
// assumes instr_exec_defines.svh is on the include path and drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`include "instr_exec_defines.svh"
module tb_move_and_return_instr_exec;
  logic                clk;               // 40 MHz clock
  logic                resetn;            // synchronous reset, active low
  logic                instr_valid;       // fetch offers a word
  logic [`INSTR_W-1:0] instr_word;        // offered word
  logic                instr_ready;       // unit takes a word
  logic [`PTR_W-1:0]   instr_pointer;     // pointer out
  logic [`PTR_W-1:0]   return_stack_top;  // stack top in
  logic                stack_pop;         // pop pulse
  logic                file_we;           // file write pulse
  logic [`FADDR_W-1:0] file_addr;         // file write address
  logic [`DATA_W-1:0]  file_wdata;        // file write data
  logic [`DATA_W-1:0]  acc;               // accumulator
  logic                global_irq_enable; // global enable
  logic                irq_enable_clear;  // enable clear in
  int                  n_errors;          // mismatches seen
  int                  check_count;       // comparisons made
  logic [`PTR_W-1:0]   exp_ptr;           // expected pointer

  move_and_return_instr_exec u_dut (
    .clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_pointer(instr_pointer), .return_stack_top(return_stack_top),
    .stack_pop(stack_pop), .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
    .acc(acc), .global_irq_enable(global_irq_enable), .irq_enable_clear(irq_enable_clear)
  );

  // free-running clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one comparison, case equality so unknowns fail
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // offer one word until taken; optionally keep valid up with an idle word afterwards
  task automatic issue(input logic [13:0] w, input logic [12:0] top, input logic g, input logic hold);
    int i;
    for (i = 0; i < 8 && instr_ready !== 1'b1; i++) @(posedge clk);
    if (instr_ready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    @(posedge clk);
    instr_valid      <= 1'b1;
    instr_word       <= w;
    return_stack_top <= top;
    irq_enable_clear <= g;
    @(posedge clk);
    irq_enable_clear <= 1'b0;
    return_stack_top <= ~top; // stack moves on after the pop
    if (hold) begin
      instr_word <= 14'h0000;
    end else begin
      instr_valid <= 1'b0;
    end
    #1;
  endtask

  // second cycle of a return: busy, then ready with the held word refused
  task automatic ret_check(input logic [12:0] top);
    chk("instr_ready", 16'h0000, 16'(instr_ready));
    chk("stack_pop", 16'h0001, 16'(stack_pop));
    chk("instr_pointer", 16'(top), 16'(instr_pointer));
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("instr_ready", 16'h0001, 16'(instr_ready));
    chk("stack_pop", 16'h0000, 16'(stack_pop));
    chk("instr_pointer", 16'(top), 16'(instr_pointer));
    exp_ptr = top;
  endtask

  // values straight after reset
  task automatic t_reset();
    chk("instr_pointer", 16'h0000, 16'(instr_pointer));
    chk("acc", 16'h0000, 16'(acc));
    chk("global_irq_enable", 16'h0000, 16'(global_irq_enable));
    chk("instr_ready", 16'h0001, 16'(instr_ready));
    chk("file_we", 16'h0000, 16'(file_we));
    chk("stack_pop", 16'h0000, 16'(stack_pop));
    exp_ptr = 13'h0000;
  endtask

  // literal load, then literal and file write back to back at top address
  task automatic t_moves();
    issue(14'h305a, 13'h0000, 1'b0, 1'b0);
    chk("acc", 16'h005a, 16'(acc));
    chk("instr_pointer", 16'(exp_ptr + 13'h0001), 16'(instr_pointer));
    chk("file_we", 16'h0000, 16'(file_we));
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= 14'h30ff;
    @(posedge clk);
    instr_word  <= 14'h00ff;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("file_we", 16'h0001, 16'(file_we));
    chk("file_addr", 16'h007f, 16'(file_addr));
    chk("file_wdata", 16'h00ff, 16'(file_wdata));
    chk("instr_pointer", 16'(exp_ptr + 13'h0003), 16'(instr_pointer));
    @(posedge clk);
    #1;
    chk("file_we", 16'h0000, 16'(file_we));
    exp_ptr = exp_ptr + 13'h0003;
  endtask

  // idle word only steps the pointer
  task automatic t_idle();
    issue(14'h0000, 13'h0000, 1'b0, 1'b0);
    chk("instr_pointer", 16'(exp_ptr + 13'h0001), 16'(instr_pointer));
    chk("acc", 16'h00ff, 16'(acc));
    chk("file_we", 16'h0000, 16'(file_we));
    chk("stack_pop", 16'h0000, 16'(stack_pop));
    // a word of another unit only steps the pointer as well
    issue(14'h3800, 13'h0000, 1'b0, 1'b0);
    chk("instr_pointer", 16'(exp_ptr + 13'h0002), 16'(instr_pointer));
    chk("acc", 16'h00ff, 16'(acc));
    chk("file_we", 16'h0000, 16'(file_we));
    exp_ptr = exp_ptr + 13'h0002;
  endtask

  // interrupt return against a clear on the same edge
  task automatic t_irq_ret();
    issue(14'h0009, 13'h1abc, 1'b1, 1'b1);
    chk("global_irq_enable", 16'h0001, 16'(global_irq_enable));
    chk("acc", 16'h00ff, 16'(acc));
    ret_check(13'h1abc);
  endtask

  // return with zero literal and full stack value
  task automatic t_ret_lit();
    issue(14'h3400, 13'h1fff, 1'b0, 1'b1);
    chk("acc", 16'h0000, 16'(acc));
    ret_check(13'h1fff);
  endtask

  // plain return keeps accumulator and a cleared enable
  task automatic t_sub_ret();
    issue(14'h30a5, 13'h0000, 1'b1, 1'b0);
    chk("acc", 16'h00a5, 16'(acc));
    chk("global_irq_enable", 16'h0000, 16'(global_irq_enable));
    issue(14'h0008, 13'h0123, 1'b0, 1'b1);
    chk("acc", 16'h00a5, 16'(acc));
    chk("global_irq_enable", 16'h0000, 16'(global_irq_enable));
    ret_check(13'h0123);
  endtask

  // reset in mid-run, then the first word straight after release
  task automatic t_mid_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    issue(14'h0000, 13'h0000, 1'b0, 1'b0);
    chk("instr_pointer", 16'h0001, 16'(instr_pointer));
  endtask

  // main sequence
  initial begin
    n_errors         = 0;
    check_count      = 0;
    resetn           = 1'b0;
    instr_valid      = 1'b0;
    instr_word       = 14'h0000;
    return_stack_top = 13'h0000;
    irq_enable_clear = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_moves();
    t_idle();
    t_irq_ret();
    t_ret_lit();
    t_sub_ret();
    t_mid_reset();
    complete_run();
  end
endmodule // tb_move_and_return_instr_exec
`default_nettype wire
